// >>> rtl/core_index_regs.vh
/*
 * Constants for the identification register bank: selector codes for
 * coprocessor reads and writes, field positions and fixed field values.
 * Assumes it is included by bare name from the bank's design files.
 */
`ifndef CORE_INDEX_REGS_VH
`define CORE_INDEX_REGS_VH

// selector codes: opcode1, CRn, CRm, opcode2
`define SEL_OPC1_ID 3'h0
`define SEL_CRN_ID 4'h0
`define SEL_CRM_ID 4'h0
`define SEL_CRM_FEAT 4'h1
`define SEL_OPC2_MAIN 3'h0
`define SEL_OPC2_CACHE 3'h1
`define SEL_OPC2_TCM 3'h2
`define SEL_OPC2_TLB 3'h3
`define SEL_OPC2_AFF 3'h5
`define SEL_OPC2_FEAT0 3'h0
`define SEL_CRN_IMPL 4'hF
`define SEL_OPC1_PWR 3'h0
`define SEL_OPC1_CBASE 3'h4
`define SEL_OPC1_TLBDBG 3'h5
`define SEL_CRM_TLB_WR 4'h4
`define SEL_CRM_TLB_VA 4'h5
`define SEL_CRM_TLB_PA 4'h6
`define SEL_OPC2_TLB_WR 3'h4
`define SEL_OPC2_TLB_DBG 3'h2
`define SEL_OPC2_ZERO 3'h0

// cache type fields
`define CACHE_FORMAT 3'h4
`define CACHE_L1_VIRTUAL_INDEX_PHYSICAL_TAG 2'h2

// translation buffer type fields
`define TLB_INSTR_LOCKABLE 8'h00
`define TLB_DATA_LOCKABLE 8'h04
`define TLB_DEPTH_LARGE 128
`define TLB_UNIFIED 1'h0

// affinity fields
`define AFF_MP_FORMAT 1'h1

// processor feature 0 state codes
`define FEAT_INSTR_STATE_FIELD_3 4'h1
`define FEAT_INSTR_STATE_FIELD_2 4'h2
`define FEAT_INSTR_STATE_FIELD_1 4'h3
`define FEAT_STATE0 4'h1

// tightly coupled memory type: none present
`define TCM_NONE 32'h00000000

// power control: latency field position
`define PWR_LAT_LSB 8
`define PWR_RESET 32'h00000000

// configuration base: kept bits [31:13]
`define CBASE_LSB 13
`define CBASE_RESET 19'h00000

`endif

// >>> rtl/cfg_capture.v
/*
 * Captures a configuration input bus once, at the first clock edge after
 * reset release, and holds it until the next reset.
 * Assumes the input is steady around the reset release.
 */
`timescale 1ns/1ps
module cfg_capture #(
   parameter W = 4
) (
   input wire ref_clk,
   input wire arst_n,
   input wire [W-1:0] din,
   output reg [W-1:0] dout,
   output reg loaded
);

   // strap capture after release, never under the async reset
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dout <= {W{1'b0}};
         loaded <= 1'b0;
      end else if (!loaded) begin
         dout <= din;
         loaded <= 1'b1;
      end
   end

endmodule // cfg_capture

// >>> rtl/core_index_bank.v
/*
 * Identification and feature register bank of the system control
 * coprocessor, with the power control, configuration base and main TLB
 * debug registers. Accesses arrive as one-cycle requests carrying the
 * coprocessor selector, mode and security state; each is answered one
 * cycle later with read data or an undefined-instruction flag.
 * Assumes the core pipeline holds requests to one per cycle and that the
 * configuration inputs are steady around reset release.
 */
//
// Functional notes
// - main id: implementor top byte, variant, format, part number, minor revision
// - one copy for both worlds; privileged access only
// - cache type gives log2 words of smallest data and instruction lines
// - level one instruction policy reads binary 10, virtual index physical tag
// - cache type format in 31:29, granules 27:24 and 23:20, zeros in bit 28 and 13:4
// - zero instruction lockable entries, four data lockable entries
// - bit 1 set for a 128-entry buffer, clear for 64
// - bit 0 clear: single unified translation buffer
// - affinity bit 31 always one
// - affinity bit 30 zero when multicore, one when single core
// - cluster number from captured inputs when multicore, else zero
// - core index in bits 1:0, below configured core count, at most three
// - feature 0: upper half zero, state codes 1,2,3,1
// - config base zero single core, else reset to peripheral base 31:13
// - power control reset value built from the latency inputs
// - main TLB debug registers refused in the non-secure world
// - config base written only in secure privileged mode
// - tightly coupled memory type reports none present
// - selector decode by opcode1, CRn, CRm, opcode2
`timescale 1ns/1ps
`include "core_index_regs.vh"
module core_index_bank #(
   parameter IMPLEMENTOR = 8'h00, // arbitrary value
   parameter VARIANT = 4'h0,
   parameter ARCH_FORMAT = 4'hF,
   parameter PART_NUMBER = 12'h000, // arbitrary value
   parameter REVISION = 4'h0,
   parameter DATA_LINE_LOG2 = 4'h3,
   parameter INSTR_LINE_LOG2 = 4'h3,
   parameter WRITEBACK_GRANULE = 4'h4,
   parameter EXCL_GRANULE = 4'h4,
   parameter TLB_ENTRIES = 64,
   parameter MULTI_CORE = 1,
   parameter NUM_CORES = 1,
   parameter CORE_INDEX = 2'h0
) (
   input wire ref_clk,
   input wire arst_n,
   input wire req_valid,
   input wire req_write,
   input wire [2:0] req_opc1,
   input wire [3:0] req_crn,
   input wire [3:0] req_crm,
   input wire [2:0] req_opc2,
   input wire [31:0] req_wdata,
   input wire req_privileged,
   input wire req_secure,
   input wire [3:0] cluster_select_inputs,
   input wire [18:0] peripheral_base_inputs,
   input wire [2:0] max_clock_latency_inputs,
   output reg rsp_valid,
   output reg rsp_undef,
   output reg [31:0] rsp_rdata,
   output reg [31:0] power_control,
   output reg init_done
);

   wire [3:0] cluster_cap;
   wire [18:0] pbase_cap;
   wire [2:0] lat_cap;
   wire cluster_ok;
   wire pbase_ok;
   wire lat_ok;
   wire caps_ok;

   // straps caught once after reset release
   cfg_capture #(.W(4)) cap_cluster (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .din(cluster_select_inputs),
      .dout(cluster_cap),
      .loaded(cluster_ok)
   );

   cfg_capture #(.W(19)) cap_pbase (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .din(peripheral_base_inputs),
      .dout(pbase_cap),
      .loaded(pbase_ok)
   );

   cfg_capture #(.W(3)) cap_lat (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .din(max_clock_latency_inputs),
      .dout(lat_cap),
      .loaded(lat_ok)
   );

   assign caps_ok = cluster_ok & pbase_ok & lat_ok;

   // fixed read values of the identification registers
   wire [31:0] main_identification;
   wire [31:0] cache_type;
   wire [31:0] tightly_coupled_memory_type;
   wire [31:0] translation_buffer_type;
   wire [31:0] multiprocessor_affinity;
   wire [31:0] processor_feature_0;
   wire translation_buffer_depth_flag;
   wire [3:0] cluster_number;
   wire [1:0] core_index;
   wire uni_flag;

   assign main_identification = {IMPLEMENTOR[7:0], VARIANT[3:0], ARCH_FORMAT[3:0],
                                 PART_NUMBER[11:0], REVISION[3:0]};
   assign cache_type = {`CACHE_FORMAT, 1'b0, WRITEBACK_GRANULE[3:0],
                        EXCL_GRANULE[3:0], DATA_LINE_LOG2[3:0],
                        `CACHE_L1_VIRTUAL_INDEX_PHYSICAL_TAG, 10'h000, INSTR_LINE_LOG2[3:0]};
   assign tightly_coupled_memory_type = `TCM_NONE;
   assign translation_buffer_depth_flag = (TLB_ENTRIES == `TLB_DEPTH_LARGE);
   assign translation_buffer_type = {8'h00, `TLB_INSTR_LOCKABLE, `TLB_DATA_LOCKABLE,
                                     6'h00, translation_buffer_depth_flag,
                                     `TLB_UNIFIED};
   assign uni_flag = (MULTI_CORE == 0) ? 1'b1 : 1'b0;
   assign cluster_number = uni_flag ? 4'h0 : cluster_cap;
   // index forced to zero unless below the configured core count
   assign core_index = (CORE_INDEX >= NUM_CORES) ? 2'h0 : CORE_INDEX[1:0];
   assign multiprocessor_affinity = {`AFF_MP_FORMAT, uni_flag, 18'h00000,
                                     cluster_number, 6'h00, core_index};
   assign processor_feature_0 = {16'h0000, `FEAT_INSTR_STATE_FIELD_3, `FEAT_INSTR_STATE_FIELD_2,
                                 `FEAT_INSTR_STATE_FIELD_1, `FEAT_STATE0};

   // writable state
   reg [18:0] cbase_reg;
   reg [18:0] cbase_next;
   reg [31:0] tlb_va_reg;
   reg [31:0] tlb_va_next;
   reg [31:0] tlb_pa_reg;
   reg [31:0] tlb_pa_next;
   reg [31:0] pwr_next;
   reg init_next;

   // selector decode
   wire is_id_grp;
   wire is_feat_grp;
   wire is_impl_grp;
   wire sel_main;
   wire sel_cache;
   wire sel_tcm;
   wire sel_tlb;
   wire sel_aff;
   wire sel_feat0;
   wire sel_pwr;
   wire sel_cbase;
   wire sel_tlb_wr;
   wire sel_tlb_va;
   wire sel_tlb_pa;
   wire sel_dbg;
   wire sel_ro_id;

   assign is_id_grp = (req_opc1 == `SEL_OPC1_ID) && (req_crn == `SEL_CRN_ID) &&
                      (req_crm == `SEL_CRM_ID);
   assign is_feat_grp = (req_opc1 == `SEL_OPC1_ID) && (req_crn == `SEL_CRN_ID) &&
                        (req_crm == `SEL_CRM_FEAT);
   assign is_impl_grp = (req_crn == `SEL_CRN_IMPL);
   assign sel_main = is_id_grp && (req_opc2 == `SEL_OPC2_MAIN);
   assign sel_cache = is_id_grp && (req_opc2 == `SEL_OPC2_CACHE);
   assign sel_tcm = is_id_grp && (req_opc2 == `SEL_OPC2_TCM);
   assign sel_tlb = is_id_grp && (req_opc2 == `SEL_OPC2_TLB);
   assign sel_aff = is_id_grp && (req_opc2 == `SEL_OPC2_AFF);
   assign sel_feat0 = is_feat_grp && (req_opc2 == `SEL_OPC2_FEAT0);
   assign sel_pwr = is_impl_grp && (req_opc1 == `SEL_OPC1_PWR) &&
                    (req_crm == 4'h0) && (req_opc2 == `SEL_OPC2_ZERO);
   assign sel_cbase = is_impl_grp && (req_opc1 == `SEL_OPC1_CBASE) &&
                      (req_crm == 4'h0) && (req_opc2 == `SEL_OPC2_ZERO);
   assign sel_tlb_wr = is_impl_grp && (req_opc1 == `SEL_OPC1_TLBDBG) &&
                       (req_crm == `SEL_CRM_TLB_WR) && (req_opc2 == `SEL_OPC2_TLB_WR);
   assign sel_tlb_va = is_impl_grp && (req_opc1 == `SEL_OPC1_TLBDBG) &&
                       (req_crm == `SEL_CRM_TLB_VA) && (req_opc2 == `SEL_OPC2_TLB_DBG);
   assign sel_tlb_pa = is_impl_grp && (req_opc1 == `SEL_OPC1_TLBDBG) &&
                       (req_crm == `SEL_CRM_TLB_PA) && (req_opc2 == `SEL_OPC2_TLB_DBG);
   assign sel_dbg = sel_tlb_wr | sel_tlb_va | sel_tlb_pa;
   assign sel_ro_id = sel_main | sel_cache | sel_tcm | sel_tlb | sel_aff | sel_feat0;

   // access legality: config base open to reads, user mode refused elsewhere
   reg legal;
   reg [31:0] rdata_sel;
   wire secure_priv;

   // write permission of the configuration base register
   assign secure_priv = req_secure && req_privileged;

   always @* begin
      legal = 1'b0;
      rdata_sel = 32'h00000000;
      if (sel_cbase) begin
         // readable from every mode and world, written by secure privileged code
         legal = !req_write || secure_priv;
         rdata_sel = (MULTI_CORE != 0) ? {cbase_reg, 13'h0000} : 32'h00000000;
      end else if (!req_privileged) begin
         legal = 1'b0;
      end else if (sel_ro_id) begin
         legal = !req_write;
         rdata_sel = sel_main ? main_identification :
                     sel_cache ? cache_type :
                     sel_tcm ? tightly_coupled_memory_type :
                     sel_tlb ? translation_buffer_type :
                     sel_aff ? multiprocessor_affinity : processor_feature_0;
      end else if (sel_pwr) begin
         legal = !req_write || req_secure;
         rdata_sel = power_control;
      end else if (sel_dbg) begin
         legal = req_secure && !(sel_tlb_wr && !req_write);
         rdata_sel = sel_tlb_va ? tlb_va_reg : tlb_pa_reg;
      end
   end

   // write strobes, one per writable register
   wire wr_take;
   wire wr_pwr;
   wire wr_cbase;
   wire wr_tlb_va;
   wire wr_tlb_pa;

   assign wr_take = req_valid && req_write && legal;
   assign wr_pwr = wr_take && sel_pwr;
   assign wr_cbase = wr_take && sel_cbase && (MULTI_CORE != 0);
   assign wr_tlb_va = wr_take && sel_tlb_va;
   assign wr_tlb_pa = wr_take && sel_tlb_pa;

   // next state of writable registers and the one-shot strap load
   always @* begin
      cbase_next = cbase_reg;
      tlb_va_next = tlb_va_reg;
      tlb_pa_next = tlb_pa_reg;
      pwr_next = power_control;
      init_next = init_done;
      if (caps_ok && !init_done) begin
         init_next = 1'b1;
         pwr_next = `PWR_RESET | ({29'h00000000, lat_cap} << `PWR_LAT_LSB);
         cbase_next = (MULTI_CORE != 0) ? pbase_cap : `CBASE_RESET;
      end else begin
         if (wr_pwr) begin
            pwr_next = req_wdata;
         end
         if (wr_cbase) begin
            cbase_next = req_wdata[31:`CBASE_LSB];
         end
         if (wr_tlb_va) begin
            tlb_va_next = req_wdata;
         end
         if (wr_tlb_pa) begin
            tlb_pa_next = req_wdata;
         end
      end
   end

   // state registers
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cbase_reg <= `CBASE_RESET;
         tlb_va_reg <= 32'h00000000;
         tlb_pa_reg <= 32'h00000000;
         power_control <= `PWR_RESET;
         init_done <= 1'b0;
      end else begin
         cbase_reg <= cbase_next;
         tlb_va_reg <= tlb_va_next;
         tlb_pa_reg <= tlb_pa_next;
         power_control <= pwr_next;
         init_done <= init_next;
      end
   end

   // registered answer, one cycle after the request
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid <= 1'b0;
         rsp_undef <= 1'b0;
         rsp_rdata <= 32'h00000000;
      end else begin
         rsp_valid <= req_valid;
         rsp_undef <= req_valid && !legal;
         rsp_rdata <= (req_valid && legal && !req_write) ? rdata_sel : 32'h00000000;
      end
   end

endmodule // core_index_bank

// >>> dv/core_index_bank_monitor.sv
/*
 * Concurrent checks on the identification register bank ports.
 * Assumes it is bound to core_index_bank and sees only its ports.
 */
`timescale 1ns/1ps
module core_index_bank_monitor (
   input logic ref_clk,
   input logic arst_n,
   input logic req_valid,
   input logic req_write,
   input logic [2:0] req_opc1,
   input logic [3:0] req_crn,
   input logic [3:0] req_crm,
   input logic [2:0] req_opc2,
   input logic req_privileged,
   input logic req_secure,
   input logic [2:0] max_clock_latency_inputs,
   input logic rsp_valid,
   input logic rsp_undef,
   input logic [31:0] rsp_rdata,
   input logic [31:0] power_control,
   input logic init_done
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // privileged read of the c0 identification group
   wire idr = req_valid && !req_write && req_privileged && req_opc1 == 3'h0 && req_crn == 4'h0;
   wire c0 = idr && req_crm == 4'h0;
   property p_ans; req_valid |=> rsp_valid; endproperty
   a_ans: assert property (p_ans) else $error("request not answered");
   property p_user;
      req_valid && !req_privileged && !(req_crn == 4'hF && req_opc1 == 3'h4)
         |=> rsp_undef && rsp_rdata == 32'h0;
   endproperty
   a_user: assert property (p_user) else $error("user access not refused");
   property p_tlbns;
      req_valid && !req_secure && req_crn == 4'hF && req_opc1 == 3'h5 |=> rsp_undef;
   endproperty
   a_tlbns: assert property (p_tlbns) else $error("debug access open to non-secure");
   property p_cbase_wr;
      req_valid && req_write && req_crn == 4'hF && req_opc1 == 3'h4 &&
         !(req_secure && req_privileged) |=> rsp_undef;
   endproperty
   a_cbase_wr: assert property (p_cbase_wr) else $error("config base write not refused");
   property p_cache;
      c0 && req_opc2 == 3'h1 |=> rsp_rdata[31:28] == 4'h8 && rsp_rdata[15:4] == 12'h800;
   endproperty
   a_cache: assert property (p_cache) else $error("cache type fixed fields");
   property p_tlb;
      c0 && req_opc2 == 3'h3 |=> rsp_rdata[23:8] == 16'h0004 && !rsp_rdata[0];
   endproperty
   a_tlb: assert property (p_tlb) else $error("translation type fields");
   property p_aff;
      c0 && req_opc2 == 3'h5 |=> rsp_rdata[31] && rsp_rdata[29:12] == 18'h0;
   endproperty
   a_aff: assert property (p_aff) else $error("affinity format bit");
   property p_feat; idr && req_crm == 4'h1 && req_opc2 == 3'h0 |=> rsp_rdata == 32'h00001231;
   endproperty
   a_feat: assert property (p_feat) else $error("feature 0 value");
   property p_tcm;
      c0 && req_opc2 == 3'h2 |=> rsp_valid && !rsp_undef && rsp_rdata == 32'h0;
   endproperty
   a_tcm: assert property (p_tcm) else $error("tcm type not empty");
   property p_pwr; $rose(init_done) |-> power_control == {21'h0, max_clock_latency_inputs, 8'h0};
   endproperty
   a_pwr: assert property (p_pwr) else $error("power control reset value");
endmodule // core_index_bank_monitor
bind core_index_bank core_index_bank_monitor i_mon (.*);

// >>> dv/tb_core_index_bank.sv
/*
 * Self-checking bench for the identification register bank.
 * Assumes the straps stay steady and one access is in flight at a time.
 */
`timescale 1ns/1ps
`include "core_index_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_core_index_bank;
   reg ref_clk = 1'h0, arst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0;
   reg req_privileged = 1'h0, req_secure = 1'h0;
   reg [2:0] req_opc1 = 3'h0, req_opc2 = 3'h0, max_clock_latency_inputs = 3'h5;
   reg [3:0] req_crn = 4'h0, req_crm = 4'h0, cluster_select_inputs = 4'hC;
   reg [18:0] peripheral_base_inputs = 19'h5A5A5;
   reg [31:0] req_wdata = 32'h0;
   wire rsp_valid, rsp_undef, init_done;
   wire [31:0] rsp_rdata, power_control;
   integer n_errors = 0, total_checks = 0, s;
   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;
   core_index_bank #(.VARIANT(4'h1), .REVISION(4'h2), .TLB_ENTRIES(128), .NUM_CORES(4),
      .CORE_INDEX(2'h2)) i_dut (.*);
   task test_done;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // one access, then compare the undefined flag and read data
   task acc(input reg w, input reg [2:0] o1, input reg [3:0] n, input reg [3:0] m,
      input reg [2:0] o2, input reg [31:0] wd, input reg p, input reg sc, input reg eu,
      input reg [31:0] ed);
      integer k;
      begin
         @(posedge ref_clk);
         req_valid <= 1'h1;
         req_write <= w;
         req_opc1 <= o1;
         req_crn <= n;
         req_crm <= m;
         req_opc2 <= o2;
         req_wdata <= wd;
         req_privileged <= p;
         req_secure <= sc;
         @(posedge ref_clk);
         req_valid <= 1'h0;
         #1;
         k = 0;
         while (rsp_valid !== 1'h1 && k < 4) begin
            @(posedge ref_clk);
            #1;
            k++;
         end
         if (k == 4) begin
            n_errors++;
            $display("BAD %0t no answer", $time);
            test_done;
         end else begin
            `CHK(rsp_undef, eu)
            `CHK(rsp_rdata, ed)
         end
      end
   endtask
   // every identification register in both worlds
   task t_ids;
      for (s = 0; s < 2; s++) begin
         acc(0, 3'h0, 4'h0, 4'h0, 3'h0, 0, 1, s, 0, 32'h001F0002);
         acc(0, 3'h0, 4'h0, 4'h0, 3'h1, 0, 1, s, 0, 32'h84438003);
         acc(0, 3'h0, 4'h0, 4'h0, 3'h2, 0, 1, s, 0, `TCM_NONE);
         acc(0, 3'h0, 4'h0, 4'h0, 3'h3, 0, 1, s, 0, 32'h00000402);
         acc(0, 3'h0, 4'h0, 4'h0, 3'h5, 0, 1, s, 0, 32'h80000C02);
         acc(0, 3'h0, 4'h0, 4'h1, 3'h0, 0, 1, s, 0, 32'h00001231);
      end
   endtask
   // refused accesses: user mode, write to id, unmapped selector
   task t_refused;
      begin
         acc(0, 3'h0, 4'h0, 4'h0, 3'h0, 0, 0, 1, 1, 32'h0);
         acc(1, 3'h0, 4'h0, 4'h0, 3'h0, 32'hFFFFFFFF, 1, 1, 1, 32'h0);
         acc(0, 3'h0, 4'h0, 4'h0, 3'h4, 0, 1, 1, 1, 32'h0);
      end
   endtask
   // strap values after reset, then configuration base writes
   task t_cbase;
      begin
         `CHK(power_control, 32'h00000500)
         acc(0, 3'h4, 4'hF, 4'h0, 3'h0, 0, 1, 0, 0, {19'h5A5A5, 13'h0000});
         acc(1, 3'h4, 4'hF, 4'h0, 3'h0, 32'h0, 1, 0, 1, 32'h0);
         acc(1, 3'h4, 4'hF, 4'h0, 3'h0, 32'h0, 0, 1, 1, 32'h0);
         acc(0, 3'h4, 4'hF, 4'h0, 3'h0, 0, 0, 1, 0, {19'h5A5A5, 13'h0000});
         acc(0, 3'h4, 4'hF, 4'h0, 3'h0, 0, 1, 1, 0, {19'h5A5A5, 13'h0000});
         acc(1, 3'h4, 4'hF, 4'h0, 3'h0, 32'hFFFFFFFF, 1, 1, 0, 32'h0);
         acc(0, 3'h4, 4'hF, 4'h0, 3'h0, 0, 1, 0, 0, 32'hFFFFE000);
         acc(0, 3'h4, 4'hF, 4'h0, 3'h0, 0, 0, 0, 0, 32'hFFFFE000);
      end
   endtask
   // translation debug registers closed to the non-secure world
   task t_tlbdbg;
      begin
         acc(1, 3'h5, 4'hF, 4'h5, 3'h2, 32'h12345678, 1, 1, 0, 32'h0);
         acc(0, 3'h5, 4'hF, 4'h5, 3'h2, 0, 1, 0, 1, 32'h0);
         acc(1, 3'h5, 4'hF, 4'h6, 3'h2, 32'h0, 1, 0, 1, 32'h0);
         acc(1, 3'h5, 4'hF, 4'h4, 3'h4, 32'h0, 1, 0, 1, 32'h0);
         acc(0, 3'h5, 4'hF, 4'h5, 3'h2, 0, 1, 1, 0, 32'h12345678);
         acc(1, 3'h5, 4'hF, 4'h6, 3'h2, 32'hCAFE0123, 1, 1, 0, 32'h0);
         acc(0, 3'h5, 4'hF, 4'h6, 3'h2, 0, 1, 1, 0, 32'hCAFE0123);
         acc(0, 3'h5, 4'hF, 4'h6, 3'h2, 0, 1, 0, 1, 32'h0);
         acc(1, 3'h5, 4'hF, 4'h4, 3'h4, 32'h1, 1, 1, 0, 32'h0);
         acc(0, 3'h5, 4'hF, 4'h4, 3'h4, 0, 1, 1, 1, 32'h0);
      end
   endtask
   // power control: read by non-secure privileged code, written only by secure code, user read refused
   task t_power;
      begin
         acc(0, 3'h0, 4'hF, 4'h0, 3'h0, 0, 1, 0, 0, 32'h00000500);
         acc(1, 3'h0, 4'hF, 4'h0, 3'h0, 32'h00000003, 1, 0, 1, 32'h0);
         `CHK(power_control, 32'h00000500)
         acc(1, 3'h0, 4'hF, 4'h0, 3'h0, 32'h00000003, 1, 1, 0, 32'h0);
         `CHK(power_control, 32'h00000003)
         acc(0, 3'h0, 4'hF, 4'h0, 3'h0, 0, 0, 1, 1, 32'h0);
      end
   endtask
   // reset, then each test in turn
   initial begin
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(init_done, 1'h1)
      t_cbase;
      $display("test cbase done");
      t_ids;
      $display("test ids done");
      t_refused;
      $display("test refused done");
      t_tlbdbg;
      $display("test tlbdbg done");
      t_power;
      $display("test power done");
      test_done;
   end
endmodule // tb_core_index_bank
